// File: verilog/wdl_pkg.sv
// Constants and types shared by the write-only two-wire target and its input filter.
// Contract
// - With no transfer running both lines rest high; that reads as idle.
// - Data falling while clock is high is a start condition.
// - Data rising while clock is high is a stop; bus then free.
// - Parties only pull lines low or release them; never drive high.
// - Bus carries 8-bit bytes each followed by one acknowledge bit.
// - First byte after start is 7-bit address plus direction bit, then acknowledge.
// - Acknowledge pulls data low through the whole acknowledge clock high phase.
// - Unaccepted address leaves data high; master may stop.
// - Accepted target refusing more bytes leaves data high; master must stop.
// - Target never pulls the clock low and never stretches it.
// - Only single-byte writes to one register; no reads.
// - The address and first data acknowledge slots of an accepted write are pulled low.
// - Write data sits in a shadow until a valid stop commits it.
// - Glitches up to 50 ns on clock and data are ignored.
// - Committed 6-bit code resets to binary 100000.
// - Output change requested by a new code starts only after the stop.
package wdl_pkg;
   localparam int unsigned CLK_MHZ       = 200;  // Core clock rate
   localparam int unsigned GLITCH_NS     = 50;   // Widest spike that is rejected
   // Longest ignored width rounds down to whole cycles
   localparam int unsigned FILT_CYC      = (GLITCH_NS * CLK_MHZ) / 1000;
   localparam int unsigned BYTE_BITS     = 8;
   localparam int unsigned CODE_W        = 6;
   localparam logic [5:0]  CODE_RST      = 6'h20;
   localparam logic [6:0]  ADDR_DEFAULT  = 7'h1A; // Arbitrary value
   localparam logic [3:0]  CNT_FULL      = 4'h8;
   localparam logic [3:0]  CNT_ONE       = 4'h1;

   typedef enum logic [2:0] {
      WDL_IDLE,
      WDL_ADDR,
      WDL_ADDR_ACK,
      WDL_DATA,
      WDL_DATA_ACK,
      WDL_IGNORE
   } wdl_state_e;
endpackage

// File: verilog/wdl_filter.sv
// Three-stage synchroniser with spike rejection for one bus line.
`timescale 1ns/100ps
`default_nettype none
module wdl_filter #(
   parameter int unsigned FILT_CYC = wdl_pkg::FILT_CYC
) (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic din,
   output logic      dout
);
   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       s3;
      logic [7:0] cnt;
      logic       out;
   } wdl_filt_s;

   wdl_filt_s r_reg;
   wdl_filt_s r_next;

   // ==========================================================
   // Elaboration check
   if (FILT_CYC < 1 || FILT_CYC > 250) begin : g_bad
      $error("wdl_filter: FILT_CYC out of range");
   end

   // ==========================================================
   // Next state
   // A level is taken only after it held FILT_CYC+1 agreeing samples, so a
   // spike of FILT_CYC cycles or less never reaches the decoder
   always_comb begin
      r_next    = r_reg;
      r_next.s1 = din;
      r_next.s2 = r_reg.s1; // First stage feeds only this flop
      r_next.s3 = r_reg.s2;
      if (r_reg.s2 != r_reg.s3 || r_reg.s3 == r_reg.out) begin
         r_next.cnt = 8'h00;
      end else if (r_reg.cnt == 8'(FILT_CYC)) begin
         r_next.out = r_reg.s3;
         r_next.cnt = 8'h00;
      end else begin
         r_next.cnt = r_reg.cnt + 8'h01;
      end
   end

   // Idle bus level is high, so every stage resets high
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, cnt: 8'h00, out: 1'b1};
      end else begin
         r_reg <= r_next;
      end
   end

   assign dout = r_reg.out;

   // ==========================================================
   // Checks
   AST_FILT_SETTLE: assert property (@(posedge clk) disable iff (!rstn)
      $changed(r_reg.out) |-> $past(r_reg.cnt) == 8'(FILT_CYC))
      else $error("Filter output moved before the line settled");
endmodule
`default_nettype wire

// File: verilog/wdl_target.sv
// Write-only two-wire bus target that loads a 6-bit regulator code on stop.
`timescale 1ns/100ps
`default_nettype none
module wdl_target #(
   parameter logic [6:0]  OWN_ADDR = wdl_pkg::ADDR_DEFAULT,
   parameter int unsigned FILT_CYC = wdl_pkg::FILT_CYC
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       scl_pin,
   input  wire logic       sda_pin,
   output logic            sda_o,
   output logic            sda_oe,
   output logic [5:0]      dac_code,
   output logic            dac_load
);
   typedef struct packed {
      wdl_pkg::wdl_state_e st;
      logic [3:0]          cnt;
      logic [7:0]          shift;
      logic [7:0]          shadow;
      logic                pend;
      logic [5:0]          code;
      logic                load;
      logic                oe;
      logic                scl_p;
      logic                sda_p;
   } wdl_tgt_s;

   wdl_tgt_s r_reg;
   wdl_tgt_s r_next;
   logic     scl_f;
   logic     sda_f;
   logic     scl_rise;
   logic     scl_fall;
   logic     start_det;
   logic     stop_det;
   logic     byte_end;

   // ==========================================================
   // Elaboration check
   // The code is cut from one received byte, so it cannot be any wider
   if (wdl_pkg::CODE_W > wdl_pkg::BYTE_BITS) begin : g_bad_cfg
      $error("wdl_target: code wider than one data byte");
   end

   // ==========================================================
   // Input conditioning
   // The clock line is only ever sampled; there is no path to drive it
   wdl_filter #(.FILT_CYC(FILT_CYC)) u_scl_filt (
      .clk  (clk),
      .rstn (rstn),
      .din  (scl_pin),
      .dout (scl_f)
   );

   wdl_filter #(.FILT_CYC(FILT_CYC)) u_sda_filt (
      .clk  (clk),
      .rstn (rstn),
      .din  (sda_pin),
      .dout (sda_f)
   );

   // ==========================================================
   // Bus events
   assign scl_rise  = scl_f & ~r_reg.scl_p;
   assign scl_fall  = ~scl_f & r_reg.scl_p;
   assign start_det = scl_f & r_reg.scl_p & r_reg.sda_p & ~sda_f;
   assign stop_det  = scl_f & r_reg.scl_p & ~r_reg.sda_p & sda_f;
   assign byte_end  = scl_fall & (r_reg.cnt == wdl_pkg::CNT_FULL);

   // ==========================================================
   // Protocol engine
   always_comb begin
      r_next       = r_reg;
      r_next.load  = 1'b0;
      r_next.scl_p = scl_f;
      r_next.sda_p = sda_f;
      if (start_det) begin
         // A fresh start drops whatever the cut-off transfer left
         r_next.st    = wdl_pkg::WDL_ADDR;
         r_next.cnt   = 4'h0;
         r_next.pend  = 1'b0;
         r_next.oe    = 1'b0;
      end else if (stop_det) begin
         // The stop's own clock high samples one bit, so up to one bit
         // counts as a clean byte boundary; more means a torn byte
         if (r_reg.pend && r_reg.st == wdl_pkg::WDL_DATA &&
             r_reg.cnt <= wdl_pkg::CNT_ONE) begin
            r_next.code = r_reg.shadow[wdl_pkg::CODE_W-1:0];
            r_next.load = 1'b1;
         end
         r_next.st   = wdl_pkg::WDL_IDLE;
         r_next.pend = 1'b0;
         r_next.oe   = 1'b0;
      end else begin
         case (r_reg.st)
            wdl_pkg::WDL_ADDR, wdl_pkg::WDL_DATA: begin
               if (scl_rise && r_reg.cnt < wdl_pkg::CNT_FULL) begin
                  r_next.shift = {r_reg.shift[6:0], sda_f}; // MSB first
                  r_next.cnt   = r_reg.cnt + 4'h1;
               end
               if (byte_end && r_reg.st == wdl_pkg::WDL_ADDR) begin
                  // Only our address with the write direction is taken
                  if (r_reg.shift[7:1] == OWN_ADDR && !r_reg.shift[0]) begin
                     r_next.st = wdl_pkg::WDL_ADDR_ACK;
                     r_next.oe = 1'b1;
                  end else begin
                     r_next.st = wdl_pkg::WDL_IGNORE; // Line stays released
                  end
               end else if (byte_end) begin
                  if (!r_reg.pend) begin
                     r_next.shadow = r_reg.shift;
                     r_next.pend   = 1'b1;
                     r_next.st     = wdl_pkg::WDL_DATA_ACK;
                     r_next.oe     = 1'b1;
                  end else begin
                     // Single-byte register: a second byte is refused and the
                     // whole write is dropped rather than half-trusted
                     r_next.st   = wdl_pkg::WDL_IGNORE;
                     r_next.pend = 1'b0;
                  end
               end
            end
            wdl_pkg::WDL_ADDR_ACK, wdl_pkg::WDL_DATA_ACK: begin
               // Held low from the eighth falling edge to the ninth
               if (scl_fall) begin
                  r_next.oe  = 1'b0;
                  r_next.st  = wdl_pkg::WDL_DATA;
                  r_next.cnt = 4'h0;
               end
            end
            default: begin
               // Idle and ignore wait for the next start or stop
            end
         endcase
      end
   end

   // Code powers up at its default
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r_reg <= '{st: wdl_pkg::WDL_IDLE, cnt: 4'h0, shift: 8'h00, shadow: 8'h00,
                    pend: 1'b0, code: wdl_pkg::CODE_RST, load: 1'b0, oe: 1'b0,
                    scl_p: 1'b1, sda_p: 1'b1};
      end else begin
         r_reg <= r_next;
      end
   end

   // Open drain: the pin is only ever pulled low or released
   assign sda_o    = 1'b0;
   assign sda_oe   = r_reg.oe;
   assign dac_code = r_reg.code;
   assign dac_load = r_reg.load;

   // ==========================================================
   // Checks
   AST_OE_ONLY_IN_ACK: assert property (@(posedge clk) disable iff (!rstn)
      sda_oe |-> (r_reg.st == wdl_pkg::WDL_ADDR_ACK ||
                  r_reg.st == wdl_pkg::WDL_DATA_ACK))
      else $error("Data line pulled outside an acknowledge slot");

   AST_ACK_HOLDS_HIGH: assert property (@(posedge clk) disable iff (!rstn)
      (sda_oe && scl_rise) |=> (sda_oe throughout (scl_f [*2])))
      else $error("Acknowledge released during clock high");

   AST_ADDR_ACK: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.st == wdl_pkg::WDL_ADDR && byte_end && !start_det && !stop_det &&
       r_reg.shift == {OWN_ADDR, 1'b0}) |=> sda_oe ##0
      r_reg.st == wdl_pkg::WDL_ADDR_ACK)
      else $error("Matching write address not acknowledged");

   AST_NO_READ_ACK: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.st == wdl_pkg::WDL_ADDR && byte_end && r_reg.shift[0])
      |=> !sda_oe [*2])
      else $error("Read request was acknowledged");

   AST_NO_FOREIGN_ACK: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.st == wdl_pkg::WDL_ADDR && byte_end && r_reg.shift[7:1] != OWN_ADDR)
      |=> !sda_oe [*2])
      else $error("Foreign address was acknowledged");

   AST_ACK_RELEASE: assert property (@(posedge clk) disable iff (!rstn)
      (sda_oe && scl_fall && !start_det && !stop_det)
      |=> (!sda_oe && r_reg.st == wdl_pkg::WDL_DATA))
      else $error("Acknowledge not released after its clock pulse");

   AST_TORN_STOP: assert property (@(posedge clk) disable iff (!rstn)
      (stop_det && r_reg.cnt > wdl_pkg::CNT_ONE)
      |=> (!dac_load && $stable(dac_code)))
      else $error("Torn byte was committed at stop");

   AST_SECOND_BYTE_NACK: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.st == wdl_pkg::WDL_DATA && byte_end && r_reg.pend && !start_det &&
       !stop_det) |=> (r_reg.st == wdl_pkg::WDL_IGNORE && !sda_oe && !r_reg.pend))
      else $error("Extra data byte was accepted");

   AST_START_RESTARTS: assert property (@(posedge clk) disable iff (!rstn)
      start_det |=> (r_reg.st == wdl_pkg::WDL_ADDR && r_reg.cnt == 4'h0 &&
                     !r_reg.pend && $stable(dac_code)))
      else $error("Start did not restart the address phase");

   AST_STOP_IDLE: assert property (@(posedge clk) disable iff (!rstn)
      stop_det |=> (r_reg.st == wdl_pkg::WDL_IDLE && !sda_oe))
      else $error("Stop did not free the bus");

   AST_CODE_ON_STOP: assert property (@(posedge clk) disable iff (!rstn)
      $changed(dac_code) |-> ($past(stop_det) && dac_load))
      else $error("Code changed without a stop");

   AST_LOAD_PULSE: assert property (@(posedge clk) disable iff (!rstn)
      dac_load |=> !dac_load)
      else $error("Load strobe longer than one cycle");

   COV_ADDR_ACK: cover property (@(posedge clk) disable iff (!rstn)
      r_reg.st == wdl_pkg::WDL_ADDR_ACK && scl_fall);
   COV_COMMIT: cover property (@(posedge clk) disable iff (!rstn) dac_load);
   COV_NACK_ADDR: cover property (@(posedge clk) disable iff (!rstn)
      r_reg.st == wdl_pkg::WDL_ADDR && byte_end && r_reg.shift[7:1] != OWN_ADDR);
   COV_RESTART: cover property (@(posedge clk) disable iff (!rstn)
      start_det && r_reg.pend);
   COV_SECOND_NACK: cover property (@(posedge clk) disable iff (!rstn)
      r_reg.st == wdl_pkg::WDL_DATA && byte_end && r_reg.pend);
endmodule
`default_nettype wire

// File: bench/wdl_master_model.sv
// Behavioural two-wire bus master that clocks writes into the target.
`timescale 1ns/100ps
`default_nettype none
module wdl_master_model #(
   parameter int unsigned Q = 125
) (
   input  wire logic clk,
   input  wire logic sda_line,
   output logic      scl_rel,
   output logic      sda_rel
);
   // ==========================================
   // Line drive: 1 means released to the pull-up
   // Lines are only pulled low or let go, never driven high
   initial begin
      scl_rel = 1'b1; // Idle bus rests high
      sda_rel = 1'b1;
   end

   // Quarter bit: 125 clk makes a 2.5 us bit, the fast-mode limit
   task automatic wait_q();
      repeat (Q) @(posedge clk);
   endtask

   // Data falls while clock is high; also serves as a repeated start
   task automatic start();
      sda_rel <= 1'b1;
      wait_q();
      scl_rel <= 1'b1;
      wait_q();
      sda_rel <= 1'b0;
      wait_q();
      scl_rel <= 1'b0;
      wait_q();
   endtask

   // Data rises while clock is high; used after any refusal too
   task automatic stop();
      sda_rel <= 1'b0;
      wait_q();
      scl_rel <= 1'b1;
      wait_q();
      sda_rel <= 1'b1;
      wait_q();
      wait_q();
   endtask

   // The first n bits of b, MSB first, with no acknowledge slot
   task automatic send_bits(input logic [7:0] b, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         sda_rel <= b[i];
         wait_q();
         scl_rel <= 1'b1;
         wait_q();
         wait_q();
         scl_rel <= 1'b0;
         wait_q();
      end
   endtask

   // Eight bits MSB first, then a released slot whose clock we make
   task automatic send_byte(input logic [7:0] b, output logic ack);
      send_bits(b, 8);
      sda_rel <= 1'b1; // Let go for the answer
      wait_q();
      scl_rel <= 1'b1;
      wait_q();
      ack = ~sda_line; // Low at middle and end of the high phase
      wait_q();
      ack = ack & ~sda_line;
      scl_rel <= 1'b0;
      wait_q();
   endtask

   // Clock spike of exactly the widest width the filter must reject
   task automatic spike_scl();
      scl_rel <= 1'b1;
      repeat (10) @(posedge clk);
      scl_rel <= 1'b0;
      wait_q();
   endtask
endmodule
`default_nettype wire

// File: bench/test_write_only_i2c_target_dac_load.sv
// Self-checking bench for the write-only target with a master model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module test_write_only_i2c_target_dac_load;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   wire logic  scl_rel;
   wire logic  sda_rel;
   wire logic  sda_pin;
   logic       sda_o;
   logic       sda_oe;
   logic [5:0] dac_code;
   logic       dac_load;
   logic       aa;
   logic       da;
   int         bad_count = 0;
   int         n_tests = 0;
   int         loads = 0;
   localparam logic [7:0] AW = {wdl_pkg::ADDR_DEFAULT, 1'b0};

   // ==========================================
   // Clock, wire resolution and load counting
   always #2.5 clk = ~clk;
   assign sda_pin = sda_rel & ~sda_oe; // Pull-up wins unless someone pulls low
   always @(posedge clk) if (dac_load === 1'b1) loads++;

   wdl_target wdl_target_inst (.clk(clk), .rstn(rstn), .scl_pin(scl_rel), .sda_pin(sda_pin),
      .sda_o(sda_o), .sda_oe(sda_oe), .dac_code(dac_code), .dac_load(dac_load));
   wdl_master_model wdl_master_model_inst (.clk(clk), .sda_line(sda_pin), .scl_rel(scl_rel),
      .sda_rel(sda_rel));

   // ==========================================
   // Scenarios
   task automatic xfer(input logic [7:0] a, input logic [7:0] d);
      wdl_master_model_inst.start();
      wdl_master_model_inst.send_byte(a, aa);
      wdl_master_model_inst.send_byte(d, da);
   endtask

   task automatic t_reset();
      `CHK("code", 6'h20, dac_code)
      `CHK("oe", 1'b0, sda_oe)
      `CHK("drive", 1'b0, sda_o)
      $display("test reset done");
   endtask

   // Bits [7:6] of the data must be dropped, so 0xE5 loads 0x25
   task automatic t_write();
      int l0;
      l0 = loads;
      xfer(AW, 8'hE5);
      `CHK("addr ack", 1'b1, aa)
      `CHK("data ack", 1'b1, da)
      `CHK("shadow", 6'h20, dac_code)
      wdl_master_model_inst.stop();
      `CHK("commit", 6'h25, dac_code)
      `CHK("loads", 1, loads - l0)
      $display("test write done");
   endtask

   // Read request, then a foreign address: neither answered
   task automatic t_refuse();
      for (int k = 0; k < 2; k++) begin
         wdl_master_model_inst.start();
         wdl_master_model_inst.send_byte(k == 0 ? AW | 8'h01 : AW ^ 8'h02, aa);
         `CHK("refused", 1'b0, aa)
         wdl_master_model_inst.send_byte(8'h0A, da);
         `CHK("ignored", 1'b0, da)
         wdl_master_model_inst.stop();
         `CHK("kept", 6'h25, dac_code)
      end
      $display("test refuse done");
   endtask

   task automatic t_second();
      xfer(AW, 8'h07);
      wdl_master_model_inst.send_byte(8'h09, da);
      `CHK("second nack", 1'b0, da)
      wdl_master_model_inst.stop();
      `CHK("no commit", 6'h25, dac_code)
      $display("test second done");
   endtask

   // A new start drops the pending byte even if a later stop arrives
   task automatic t_restart();
      xfer(AW, 8'h13);
      wdl_master_model_inst.start();
      wdl_master_model_inst.send_byte(AW ^ 8'h04, aa);
      wdl_master_model_inst.stop();
      `CHK("discard", 6'h25, dac_code)
      $display("test restart done");
   endtask

   // A 50 ns clock spike after the ack must not count as a bit
   task automatic t_glitch();
      xfer(AW, 8'h3C);
      wdl_master_model_inst.spike_scl();
      wdl_master_model_inst.stop();
      `CHK("spike", 6'h3C, dac_code)
      $display("test glitch done");
   endtask

   // Three bits of a further byte before the stop tear it: nothing commits
   task automatic t_torn();
      int l0;
      l0 = loads;
      xfer(AW, 8'h11);
      `CHK("torn ack", 1'b1, da)
      wdl_master_model_inst.send_bits(8'hA0, 3);
      wdl_master_model_inst.stop();
      `CHK("torn code", 6'h20, dac_code)
      `CHK("torn loads", 0, loads - l0)
      $display("test torn done");
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ==========================================
   // Main sequence and watchdog
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (10) @(posedge clk);
      t_reset();
      t_write();
      t_refuse();
      t_second();
      t_restart();
      t_glitch();
      // A reset in mid-run must bring the code back to its default
      rstn <= 1'b0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (10) @(posedge clk);
      t_reset();
      t_torn();
      print_verdict();
   end

   // Tests need about 81200 cycles at the fast-mode rate; allow some margin
   initial begin
      repeat (95000) @(posedge clk);
      bad_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
